// ### hw/regulator_event_pkg.sv
// register offsets, bit positions, reset values and timing for the
// regulator event and live status group.
// assumes a 100 MHz core clock and a byte-wide internal register port.
`default_nettype none

package regulator_event_pkg;

  // ===========================================================
  // register offsets
  localparam logic [7:0] CONVERTER_EVENT_FLAGS_ADDR = 8'h1B;
  localparam logic [7:0] LINEAR_REGULATOR_EVENT_FLAGS_ADDR = 8'h1C;
  localparam logic [7:0] TOP_LIVE_STATUS_ADDR = 8'h1D;
  localparam logic [7:0] CONVERTER_LIVE_STATUS_ADDR = 8'h1E;

  // ===========================================================
  // event register fields (same layout for converters and regulators)
  localparam int UNIT1_POWER_GOOD_BIT = 6;
  localparam int UNIT1_SHORT_BIT = 5;
  localparam int UNIT1_CURRENT_LIMIT_BIT = 4;
  localparam int UNIT0_POWER_GOOD_BIT = 2;
  localparam int UNIT0_SHORT_BIT = 1;
  localparam int UNIT0_CURRENT_LIMIT_BIT = 0;
  localparam logic [7:0] EVENT_WRITABLE_MASK = 8'h77;

  // ===========================================================
  // top live status fields
  localparam int POWER_GOOD_PIN_STATE_BIT = 7;
  localparam int SYNC_CLOCK_INVALID_BIT = 4;
  localparam int THERMAL_SHUTDOWN_STATE_BIT = 3;
  localparam int THERMAL_WARNING_STATE_BIT = 2;
  localparam int INPUT_OVERVOLTAGE_STATE_BIT = 1;

  // ===========================================================
  // converter live status fields
  localparam int CONV1_ENABLED_BIT = 7;
  localparam int CONV1_OUTPUT_INVALID_BIT = 6;
  localparam int CONV1_CURRENT_LIMIT_BIT = 4;
  localparam int CONV0_ENABLED_BIT = 3;
  localparam int CONV0_OUTPUT_INVALID_BIT = 2;
  localparam int CONV0_CURRENT_LIMIT_BIT = 0;

  // ===========================================================
  // reset values
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ===========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHORT_TIME_MS = 1;
  localparam int NS_PER_MS = 1000000;
  localparam int SHORT_CYCLES = (SHORT_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
  localparam int SHORT_COUNT_WIDTH = 32;

  // ===========================================================
  // short filter states
  typedef enum logic [2:0] {
    FILT_IDLE = 3'b001,
    FILT_COUNT = 3'b010,
    FILT_HIT = 3'b100
  } short_filter_state_type;

endpackage

`default_nettype wire

// ### hw/short_duration_filter.sv
// one short-circuit duration filter: raises expired once the output has
// been below its short threshold for more than the configured time.
// assumes below is synchronous to clk.
`default_nettype none

module short_duration_filter
  import regulator_event_pkg::*;
#(
  parameter int HOLD_CYCLES = SHORT_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic below,
  output logic expired
);

  // ===========================================================
  // state
  short_filter_state_type state_r, state_nxt;
  logic [SHORT_COUNT_WIDTH-1:0] count_r, count_nxt;
  localparam logic [SHORT_COUNT_WIDTH-1:0] HOLD_LAST =
    SHORT_COUNT_WIDTH'(HOLD_CYCLES);

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      FILT_IDLE: begin
        count_nxt = '0;
        if (below) begin
          state_nxt = FILT_COUNT;
          count_nxt = SHORT_COUNT_WIDTH'(1);
        end
      end
      FILT_COUNT: begin
        if (!below) begin
          state_nxt = FILT_IDLE;
          count_nxt = '0;
        end else if (count_r >= HOLD_LAST) begin
          state_nxt = FILT_HIT;
        end else begin
          count_nxt = count_r + SHORT_COUNT_WIDTH'(1);
        end
      end
      FILT_HIT: begin
        if (!below) begin
          state_nxt = FILT_IDLE;
          count_nxt = '0;
        end
      end
      default: begin
        state_nxt = FILT_IDLE;
        count_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= FILT_IDLE;
      count_r <= '0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
    end
  end

  assign expired = (state_r == FILT_HIT);

endmodule // short_duration_filter

`default_nettype wire

// ### hw/regulator_event_status_flags.sv
// event latch and live status registers for two converters and two
// linear regulators, reached over the internal register port behind the
// serial control interface.
// assumes all monitor inputs and the register port are synchronous to clk.
`default_nettype none

// Summary of operation
// - converter power-good event sets bit 6/2
// - converter below short over 1 ms sets 5/1
// - converter current limit sets bit 4/0
// - event flag cleared only by writing one
// - regulator power-good event sets bit 6/2
// - regulator below short over 1 ms sets 5/1
// - regulator current limit sets bit 4/0
// - top status bit 7 shows power-good pin
// - top status bit 4 shows sync clock invalid
// - top status bit 3 shows thermal shutdown
// - top status bit 2 shows thermal warning
// - top status bit 1 shows input overvoltage
// - converter status bits 7/3 show enables
// - converter status bits 6/2 show output invalid
// - converter status bits 4/0 show current limit
// - all flags and status reset to zero
// - converter summary clears when event register zero
// - regulator summary clears when event register zero
module regulator_event_status_flags
  import regulator_event_pkg::*;
#(
  parameter int SHORT_HOLD_CYCLES = SHORT_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic power_good_pin,
  input wire logic sync_clock_invalid,
  input wire logic thermal_shutdown,
  input wire logic thermal_warning,
  input wire logic input_overvoltage,
  input wire logic [1:0] conv_enabled,
  input wire logic [1:0] conv_output_invalid,
  input wire logic [1:0] conv_current_limit,
  input wire logic [1:0] conv_below_short,
  input wire logic [1:0] linreg_output_invalid,
  input wire logic [1:0] linreg_current_limit,
  input wire logic [1:0] linreg_below_short,
  output logic conv_summary_flag,
  output logic linear_summary_flag
);

  // ===========================================================
  // helpers
  function automatic logic [7:0] w1c_next(
    input logic [7:0] flags,
    input logic [7:0] set,
    input logic wr,
    input logic [7:0] wdata
  );
    logic [7:0] clr;
    clr = wr ? (wdata & EVENT_WRITABLE_MASK) : 8'h00;
    w1c_next = ((flags & ~clr) | set) & EVENT_WRITABLE_MASK;
  endfunction

  function automatic logic [7:0] event_vector(
    input logic [1:0] pg_event,
    input logic [1:0] short_event,
    input logic [1:0] limit_event
  );
    logic [7:0] v;
    v = 8'h00;
    v[UNIT1_POWER_GOOD_BIT] = pg_event[1];
    v[UNIT1_SHORT_BIT] = short_event[1];
    v[UNIT1_CURRENT_LIMIT_BIT] = limit_event[1];
    v[UNIT0_POWER_GOOD_BIT] = pg_event[0];
    v[UNIT0_SHORT_BIT] = short_event[0];
    v[UNIT0_CURRENT_LIMIT_BIT] = limit_event[0];
    event_vector = v;
  endfunction

  // ===========================================================
  // short-circuit duration filters
  logic [3:0] below_all;
  logic [3:0] short_expired;

  assign below_all = {linreg_below_short, conv_below_short};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_short
      short_duration_filter #(
        .HOLD_CYCLES(SHORT_HOLD_CYCLES)
      ) u_filter (
        .clk(clk),
        .arst_n(arst_n),
        .below(below_all[gi]),
        .expired(short_expired[gi])
      );
    end
  endgenerate

  // ===========================================================
  // event flags
  logic [7:0] conv_event_r, conv_event_nxt;
  logic [7:0] lin_event_r, lin_event_nxt;
  logic [1:0] conv_invalid_prev_r, conv_invalid_prev_nxt;
  logic [1:0] lin_invalid_prev_r, lin_invalid_prev_nxt;
  logic conv_summary_r, conv_summary_nxt;
  logic lin_summary_r, lin_summary_nxt;
  logic [1:0] conv_pg_event;
  logic [1:0] lin_pg_event;
  logic [7:0] conv_set;
  logic [7:0] lin_set;
  logic conv_event_wr;
  logic lin_event_wr;

  always_comb begin
    conv_event_wr = reg_wr_en && (reg_addr == CONVERTER_EVENT_FLAGS_ADDR);
    lin_event_wr = reg_wr_en &&
                   (reg_addr == LINEAR_REGULATOR_EVENT_FLAGS_ADDR);
    conv_pg_event = conv_output_invalid ^ conv_invalid_prev_r;
    lin_pg_event = linreg_output_invalid ^ lin_invalid_prev_r;
    conv_set = event_vector(conv_pg_event, short_expired[1:0],
                            conv_current_limit);
    lin_set = event_vector(lin_pg_event, short_expired[3:2],
                           linreg_current_limit);
    conv_event_nxt = w1c_next(conv_event_r, conv_set, conv_event_wr,
                              reg_wdata);
    lin_event_nxt = w1c_next(lin_event_r, lin_set, lin_event_wr,
                             reg_wdata);
    conv_invalid_prev_nxt = conv_output_invalid;
    lin_invalid_prev_nxt = linreg_output_invalid;
    conv_summary_nxt = |conv_event_nxt;
    lin_summary_nxt = |lin_event_nxt;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_event_r <= EVENT_RESET;
      lin_event_r <= EVENT_RESET;
      conv_invalid_prev_r <= 2'h0;
      lin_invalid_prev_r <= 2'h0;
      conv_summary_r <= 1'b0;
      lin_summary_r <= 1'b0;
    end else begin
      conv_event_r <= conv_event_nxt;
      lin_event_r <= lin_event_nxt;
      conv_invalid_prev_r <= conv_invalid_prev_nxt;
      lin_invalid_prev_r <= lin_invalid_prev_nxt;
      conv_summary_r <= conv_summary_nxt;
      lin_summary_r <= lin_summary_nxt;
    end
  end

  assign conv_summary_flag = conv_summary_r;
  assign linear_summary_flag = lin_summary_r;

  // ===========================================================
  // live status
  logic [7:0] top_stat_r, top_stat_nxt;
  logic [7:0] conv_stat_r, conv_stat_nxt;

  always_comb begin
    top_stat_nxt = STATUS_RESET;
    top_stat_nxt[POWER_GOOD_PIN_STATE_BIT] = power_good_pin;
    top_stat_nxt[SYNC_CLOCK_INVALID_BIT] = sync_clock_invalid;
    top_stat_nxt[THERMAL_SHUTDOWN_STATE_BIT] = thermal_shutdown;
    top_stat_nxt[THERMAL_WARNING_STATE_BIT] = thermal_warning;
    top_stat_nxt[INPUT_OVERVOLTAGE_STATE_BIT] = input_overvoltage;
    conv_stat_nxt = STATUS_RESET;
    conv_stat_nxt[CONV1_ENABLED_BIT] = conv_enabled[1];
    conv_stat_nxt[CONV0_ENABLED_BIT] = conv_enabled[0];
    conv_stat_nxt[CONV1_OUTPUT_INVALID_BIT] = conv_output_invalid[1];
    conv_stat_nxt[CONV0_OUTPUT_INVALID_BIT] = conv_output_invalid[0];
    conv_stat_nxt[CONV1_CURRENT_LIMIT_BIT] = conv_current_limit[1];
    conv_stat_nxt[CONV0_CURRENT_LIMIT_BIT] = conv_current_limit[0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      top_stat_r <= STATUS_RESET;
      conv_stat_r <= STATUS_RESET;
    end else begin
      top_stat_r <= top_stat_nxt;
      conv_stat_r <= conv_stat_nxt;
    end
  end

  // ===========================================================
  // read port
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    case (reg_addr)
      CONVERTER_EVENT_FLAGS_ADDR: rdata_nxt = conv_event_r;
      LINEAR_REGULATOR_EVENT_FLAGS_ADDR: rdata_nxt = lin_event_r;
      TOP_LIVE_STATUS_ADDR: rdata_nxt = top_stat_r;
      CONVERTER_LIVE_STATUS_ADDR: rdata_nxt = conv_stat_r;
      default: rdata_nxt = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= READ_UNMAPPED;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule // regulator_event_status_flags

`default_nettype wire

// ### verif/regulator_event_status_flags_sva.sv
// checker for the event and live status group, bound into the top.
// assumes the bind passes on the short hold count.
`default_nettype none

module regulator_event_checker
  import regulator_event_pkg::*;
#(
  parameter int SHORT_HOLD_CYCLES = SHORT_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic [1:0] conv_output_invalid,
  input wire logic [1:0] conv_current_limit,
  input wire logic [1:0] conv_below_short,
  input wire logic [1:0] linreg_output_invalid,
  input wire logic [1:0] linreg_current_limit,
  input wire logic [1:0] linreg_below_short,
  input wire logic conv_summary_flag,
  input wire logic linear_summary_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // run length of a held short on unit 0
  logic [31:0] conv_run_r, conv_run_nxt, lin_run_r, lin_run_nxt;
  always_comb begin
    conv_run_nxt = conv_below_short[0] ? conv_run_r + 32'h1 : 32'h0;
    lin_run_nxt = linreg_below_short[0] ? lin_run_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_run_r <= 32'h0;
      lin_run_r <= 32'h0;
    end else begin
      conv_run_r <= conv_run_nxt;
      lin_run_r <= lin_run_nxt;
    end
  end
  // ==========
  // properties
  property p_conv_limit;
    |conv_current_limit |=> conv_summary_flag;
  endproperty
  a_conv_limit: assert property (p_conv_limit)
    else $error("converter limit did not raise summary");
  property p_lin_limit;
    |linreg_current_limit |=> linear_summary_flag;
  endproperty
  a_lin_limit: assert property (p_lin_limit)
    else $error("regulator limit did not raise summary");
  property p_conv_pg;
    $changed(conv_output_invalid) |=> conv_summary_flag;
  endproperty
  a_conv_pg: assert property (p_conv_pg)
    else $error("converter power good event missed");
  property p_lin_pg;
    $changed(linreg_output_invalid) |=> linear_summary_flag;
  endproperty
  a_lin_pg: assert property (p_lin_pg)
    else $error("regulator power good event missed");
  property p_conv_fall;
    $fell(conv_summary_flag) |-> $past(reg_wr_en) &&
      $past(reg_addr) == CONVERTER_EVENT_FLAGS_ADDR;
  endproperty
  a_conv_fall: assert property (p_conv_fall)
    else $error("converter summary fell without a clear");
  property p_lin_fall;
    $fell(linear_summary_flag) |-> $past(reg_wr_en) &&
      $past(reg_addr) == LINEAR_REGULATOR_EVENT_FLAGS_ADDR;
  endproperty
  a_lin_fall: assert property (p_lin_fall)
    else $error("regulator summary fell without a clear");
  property p_conv_short;
    conv_run_r == SHORT_HOLD_CYCLES + 3 |-> conv_summary_flag;
  endproperty
  a_conv_short: assert property (p_conv_short)
    else $error("converter short not latched in time");
  property p_lin_short;
    lin_run_r == SHORT_HOLD_CYCLES + 3 |-> linear_summary_flag;
  endproperty
  a_lin_short: assert property (p_lin_short)
    else $error("regulator short not latched in time");
  property p_zero_write;
    reg_wr_en && reg_addr == CONVERTER_EVENT_FLAGS_ADDR && conv_summary_flag
      && (reg_wdata & EVENT_WRITABLE_MASK) == 8'h00 |=> conv_summary_flag;
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("write of zeros cleared a flag");
endmodule // regulator_event_checker

bind regulator_event_status_flags regulator_event_checker #(
  .SHORT_HOLD_CYCLES(SHORT_HOLD_CYCLES)
) checker_u (
  .clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata,
  .conv_output_invalid, .conv_current_limit, .conv_below_short,
  .linreg_output_invalid, .linreg_current_limit, .linreg_below_short,
  .conv_summary_flag, .linear_summary_flag
);

`default_nettype wire

// ### verif/reg_host_model.sv
// host side of the internal register port: byte reads and writes.
// assumes one bench process calls its tasks at a time.
`default_nettype none

module reg_host_model (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
  end
  // ==========
  // byte write and read tasks; a write of ones clears events
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = v;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 v = reg_rdata;
  endtask
endmodule // reg_host_model

`default_nettype wire

// ### verif/regulator_event_status_flags_tb.sv
// self-checking bench for the event and live status group.
// assumes the host model drives the register port.
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module regulator_event_status_flags_tb
  import regulator_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int H = 10;
  logic clk, arst_n, pg_pin, sync_bad, t_sd, t_warn, ovp, reg_wr_en;
  logic [1:0] en;
  logic [1:0] inv [2];
  logic [1:0] lim [2];
  logic [1:0] blw [2];
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  wire [1:0] sum;
  int errors, n_checks;
  logic [7:0] all_a [5] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h20};
  logic [7:0] top_m [6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h00};
  regulator_event_status_flags #(.SHORT_HOLD_CYCLES(H)) dut_u (
    .clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rdata,
    .power_good_pin(pg_pin), .sync_clock_invalid(sync_bad),
    .thermal_shutdown(t_sd), .thermal_warning(t_warn),
    .input_overvoltage(ovp), .conv_enabled(en),
    .conv_output_invalid(inv[0]), .conv_current_limit(lim[0]),
    .conv_below_short(blw[0]), .linreg_output_invalid(inv[1]),
    .linreg_current_limit(lim[1]), .linreg_below_short(blw[1]),
    .conv_summary_flag(sum[0]), .linear_summary_flag(sum[1]));
  reg_host_model host_u (.clk, .reg_rdata, .reg_addr, .reg_wr_en,
    .reg_wdata);
  // ==========
  // tasks
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task automatic conv_stat(input logic [1:0] e, v, l, input logic [7:0] x);
    @(posedge clk);
    #1 en = e;
    inv[0] = v;
    lim[0] = l;
    chk_rd(CONVERTER_LIVE_STATUS_ADDR, x);
  endtask
  task automatic hold(input int lin, input int u, input int n);
    @(posedge clk);
    #1 blw[lin][u] = 1'b1;
    repeat (n) @(posedge clk);
    #1 blw[lin][u] = 1'b0;
  endtask
  task automatic ev_case(input int lin, input int u);
    logic [7:0] a, m, s;
    a = lin ? LINEAR_REGULATOR_EVENT_FLAGS_ADDR : CONVERTER_EVENT_FLAGS_ADDR;
    m = 8'h05 << (4 * u);
    s = 8'h02 << (4 * u);
    @(posedge clk);
    #1 inv[lin][u] = 1'b1;
    lim[lin][u] = 1'b1;
    @(posedge clk);
    #1 inv[lin][u] = 1'b0;
    lim[lin][u] = 1'b0;
    chk_rd(a, m);
    `CHK("summary", 1'b1, sum[lin])
    host_u.wr(a, 8'h88);
    chk_rd(a, m);
    host_u.wr(a, m);
    chk_rd(a, 8'h00);
    `CHK("summary", 1'b0, sum[lin])
    hold(lin, u, H);
    chk_rd(a, 8'h00);
    hold(lin, u, H + 4);
    chk_rd(a, s);
    host_u.wr(a, s);
    chk_rd(a, 8'h00);
    $display("event test %0d %0d done", lin, u);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    errors++;
    $display("Error watchdog expected end seen hang");
    finish_test;
  end
  initial begin
    errors = 0;
    n_checks = 0;
    arst_n = 1'b0;
    {pg_pin, sync_bad, t_sd, t_warn, ovp} = 5'h00;
    en = 2'b00;
    inv = '{default: 2'b00};
    lim = '{default: 2'b00};
    blw = '{default: 2'b00};
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    foreach (all_a[k]) chk_rd(all_a[k], 8'h00);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      #1 {pg_pin, sync_bad, t_sd, t_warn, ovp} = 5'h10 >> i;
      chk_rd(TOP_LIVE_STATUS_ADDR, top_m[i]);
    end
    for (int k = 2; k < 5; k++) host_u.wr(all_a[k], 8'hFF);
    for (int k = 2; k < 5; k++) chk_rd(all_a[k], 8'h00);
    $display("live status test done");
    conv_stat(2'b10, 2'b10, 2'b01, 8'hC1);
    conv_stat(2'b01, 2'b01, 2'b10, 8'h1C);
    conv_stat(2'b00, 2'b00, 2'b00, 8'h00);
    host_u.wr(CONVERTER_EVENT_FLAGS_ADDR, 8'hFF);
    chk_rd(CONVERTER_EVENT_FLAGS_ADDR, 8'h00);
    $display("converter status test done");
    for (int lin = 0; lin < 2; lin++) begin
      for (int u = 0; u < 2; u++) ev_case(lin, u);
    end
    finish_test;
  end
endmodule // regulator_event_status_flags_tb

`default_nettype wire
